// >>> hw/bwwc_pkg.sv
// package: register map, field positions, reset values and carrier types
package bwwc_pkg;
	localparam logic [6:0] ADDR_WATCHDOG_CONTROL_REG = 7'h03;
	localparam logic [6:0] ADDR_BUS_A = 7'h04;
	localparam logic [6:0] ADDR_BUS_B = 7'h05;
	localparam logic [6:0] ADDR_WAKE_A = 7'h06;
	localparam logic [6:0] ADDR_WAKE_B = 7'h07;
	localparam logic [7:0] RST_WATCHDOG_CONTROL_REG = 8'h14;
	localparam logic [7:0] RST_BUS_A = 8'h20;
	localparam logic [7:0] RST_BUS_B = 8'h00;
	localparam logic [7:0] RST_WAKE_A = 8'h00;
	localparam logic [7:0] RST_WAKE_B = 8'h01;
	// restart: keep-masks and forced-one values
	localparam logic [7:0] RSTRT_KEEP_WD = 8'h98;
	localparam logic [7:0] RSTRT_SET_WD = 8'h04;
	localparam logic [7:0] RSTRT_KEEP_BUS_B = 8'h1B;
	localparam logic [7:0] RSTRT_KEEP_WAKE_A = 8'h40;
	localparam logic [7:0] RSTRT_KEEP_WAKE_B = 8'h01;
	// writable masks, reserved bits stay zero
	localparam logic [7:0] WMASK_BUS_A = 8'hFB;
	localparam logic [7:0] WMASK_BUS_B = 8'h1B;
	localparam logic [7:0] WMASK_WAKE_A = 8'h44;
	localparam logic [7:0] WMASK_WAKE_B = 8'h01;
	localparam int WD_STOP_OFF_BIT = 6;
	localparam int WATCHDOG_WINDOW_SEL_BIT = 5;
	localparam int WD_LIMIT_BIT = 3;
	localparam int WD_PER_MSB = 2;
	localparam int BUS_FLASH_BIT = 7;
	localparam int BUS_LSM_BIT = 6;
	localparam int BUS_TXDTO_BIT = 5;
	localparam int LIN_HI_LSB = 3;
	localparam int LIN_LO_LSB = 0;
	localparam int WAKE_TIMER_BIT = 6;
	localparam int WAKE_STOP_WD_BIT = 2;
	localparam int WAKE_PIN_BIT = 0;
	localparam int SPI_FRAME_BITS = 16;
	localparam int SPI_ADDR_BITS = 8;
	localparam logic [1:0] WD_MAX_RESETS = 2'd3;
	localparam logic [8:0] WD_MS_0 = 9'd10;
	localparam logic [8:0] WD_MS_1 = 9'd20;
	localparam logic [8:0] WD_MS_2 = 9'd50;
	localparam logic [8:0] WD_MS_3 = 9'd100;
	localparam logic [8:0] WD_MS_4 = 9'd200;
	localparam logic [8:0] WD_MS_5 = 9'd500;
	typedef enum logic [1:0] {
		TRX_OFF = 2'b00,
		TRX_WAKE = 2'b01,
		TRX_RX_ONLY = 2'b10,
		TRX_NORMAL = 2'b11
	} bwwc_trx_t;
	typedef enum logic [1:0] {
		SYS_NORMAL = 2'b00,
		SYS_STOP = 2'b01,
		SYS_SLEEP = 2'b10,
		SYS_RESTART = 2'b11
	} bwwc_sys_t;
	typedef struct packed {
		logic csn_n;
		logic sck;
		logic sdi;
	} bwwc_spi_in_t;
	typedef struct packed {
		bwwc_trx_t can;
		bwwc_trx_t first_lin_mode;
		bwwc_trx_t second_lin_mode;
		bwwc_trx_t third_lin_mode;
	} bwwc_trx_set_t;
endpackage : bwwc_pkg

// >>> hw/bwwc_ctrl_regs.sv
// control register bank behind the 16-bit serial port
//
// Summary of operation
// - reset-limit 0 resets on every watchdog fail; 1 stops after three consecutive.
// - watchdog period code decodes to 10,20,50,100,200,500 ms; 110 and 111 reserved.
// - flash bit 0 keeps LIN slope control, 1 disables it for fast flashing.
// - low-slope bit picks normal slope at 0, low slope at 1.
// - transmit dominant time-out enable bit, resets to 1.
// - first LIN mode field: off, wake, receive-only, normal.
// - CAN mode field bits 1:0 uses the same four-way encoding.
// - CAN normal becomes wake capable in stop/sleep, field kept, restored later.
// - each LIN normal becomes wake capable in stop/sleep, field kept.
// - second control register holds third and second LIN mode fields.
// - reserved bits always read zero whatever is written.
// - timer wake enable bit gates periodic timer as wake source.
// - stop watchdog-off bit disables watchdog in stop; hardware may set it.
// - wake pin enable bit, power-on 1, kept through restart.
// - second bus register clears on reset; restart keeps only LIN fields.
// - restart keeps only wake pin enable in second wake register.
// - watchdog register write needs even parity, else serial fail and ignored.
// - window bit selects time-out watchdog at 0, window watchdog at 1.
`timescale 1ns/10ps
module bwwc_ctrl_regs
	import bwwc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire bwwc_spi_in_t i_spi,
	input wire bwwc_sys_t i_sys_mode,
	input wire logic i_soft_rst,
	input wire logic i_wd_fail,
	input wire logic i_wd_trigger_ok,
	input wire logic i_hw_stop_wd_set,
	input wire logic i_hw_stop_wd_clr,
	input wire logic i_spi_fail_clr,
	output logic o_spi_sdo,
	output logic o_spi_fail,
	output bwwc_trx_set_t o_trx_mode,
	output logic o_lin_slope_off,
	output logic o_lin_low_slope_sel,
	output logic o_lin_tx_dominant_timeout_en,
	output logic o_periodic_timer_wake_en,
	output logic o_wake_pin_source_en,
	output logic o_stop_watchdog_off,
	output logic o_watchdog_window_sel,
	output logic [8:0] o_watchdog_period_ms,
	output logic o_wd_reset
);
	typedef struct packed {
		logic [7:0] wd;
		logic [7:0] bus_a;
		logic [7:0] bus_b;
		logic [7:0] wake_a;
		logic [7:0] wake_b;
		logic sck_prev;
		logic csn_prev;
		logic [4:0] bit_cnt;
		logic [15:0] rx_sh;
		logic [7:0] tx_sh;
		logic sdo;
		logic spi_fail;
		bwwc_sys_t mode_prev;
		bwwc_trx_set_t trx;
		logic [8:0] period_ms;
		logic [1:0] wd_rst_cnt;
		logic wd_reset;
		logic stop_wd_off;
	} bwwc_state_t;

	bwwc_state_t r;
	bwwc_state_t r_nxt;

	function automatic logic [7:0] read_reg(input bwwc_state_t s, input logic [6:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == ADDR_WATCHDOG_CONTROL_REG) begin
			d = s.wd;
		end else if (a == ADDR_BUS_A) begin
			d = s.bus_a & WMASK_BUS_A;
		end else if (a == ADDR_BUS_B) begin
			d = s.bus_b & WMASK_BUS_B;
		end else if (a == ADDR_WAKE_A) begin
			d = s.wake_a & WMASK_WAKE_A;
		end else if (a == ADDR_WAKE_B) begin
			d = s.wake_b & WMASK_WAKE_B;
		end
		return d;
	endfunction : read_reg

	// normal field passes; in stop/sleep a normal field runs wake capable
	function automatic bwwc_trx_t eff_mode(input logic [1:0] f, input bwwc_sys_t m);
		bwwc_trx_t e;
		e = bwwc_trx_t'(f);
		if ((m == SYS_STOP || m == SYS_SLEEP) && e == TRX_NORMAL) begin
			e = TRX_WAKE;
		end
		return e;
	endfunction : eff_mode

	logic sck_rise;
	logic sck_fall;
	logic frame_end;
	logic [6:0] rx_addr;
	logic rx_wr;
	logic [7:0] rx_data;
	logic restart_entry;
	logic wd_par_err;

	always_comb begin
		sck_rise = i_spi.sck && !r.sck_prev && !i_spi.csn_n;
		sck_fall = !i_spi.sck && r.sck_prev && !i_spi.csn_n;
		frame_end = i_spi.csn_n && !r.csn_prev;
		rx_addr = r.rx_sh[6:0];
		rx_wr = r.rx_sh[7];
		rx_data = r.rx_sh[15:8];
		restart_entry = (i_sys_mode == SYS_RESTART) && (r.mode_prev != SYS_RESTART);
		wd_par_err = frame_end && r.bit_cnt == 5'(SPI_FRAME_BITS) && rx_wr
			&& rx_addr == ADDR_WATCHDOG_CONTROL_REG && (^rx_data);
	end

	always_comb begin
		r_nxt = r;
		r_nxt.sck_prev = i_spi.sck;
		r_nxt.csn_prev = i_spi.csn_n;
		r_nxt.mode_prev = i_sys_mode;
		r_nxt.wd_reset = 1'b0;
		if (i_spi.csn_n) begin
			r_nxt.bit_cnt = 5'd0;
			r_nxt.sdo = 1'b0;
		end else if (sck_rise) begin
			// lsb first: address, access bit, then data byte
			r_nxt.rx_sh = {i_spi.sdi, r.rx_sh[15:1]};
			// count stops one past a full frame so a long frame never commits
			if (r.bit_cnt != 5'(SPI_FRAME_BITS + 1)) begin
				r_nxt.bit_cnt = r.bit_cnt + 5'd1;
			end
			if (r.bit_cnt == 5'(SPI_ADDR_BITS - 1)) begin
				r_nxt.tx_sh = read_reg(r, r_nxt.rx_sh[14:8]);
			end
		end else if (sck_fall && r.bit_cnt >= 5'(SPI_ADDR_BITS)) begin
			r_nxt.sdo = r.tx_sh[0];
			r_nxt.tx_sh = {1'b0, r.tx_sh[7:1]};
		end
		// a short or long frame is dropped whole
		if (frame_end && r.bit_cnt == 5'(SPI_FRAME_BITS) && rx_wr) begin
			if (rx_addr == ADDR_WATCHDOG_CONTROL_REG) begin
				if (^rx_data) begin
					r_nxt.spi_fail = 1'b1;
				end else begin
					r_nxt.wd = rx_data;
				end
			end else if (rx_addr == ADDR_BUS_A) begin
				r_nxt.bus_a = rx_data & WMASK_BUS_A;
			end else if (rx_addr == ADDR_BUS_B) begin
				r_nxt.bus_b = rx_data & WMASK_BUS_B;
			end else if (rx_addr == ADDR_WAKE_A) begin
				r_nxt.wake_a = rx_data & WMASK_WAKE_A;
			end else if (rx_addr == ADDR_WAKE_B) begin
				r_nxt.wake_b = rx_data & WMASK_WAKE_B;
			end
		end
		// hardware update beats a same-cycle host write
		if (i_hw_stop_wd_set) begin
			r_nxt.wd[WD_STOP_OFF_BIT] = 1'b1;
			r_nxt.wake_a[WAKE_STOP_WD_BIT] = 1'b1;
		end else if (i_hw_stop_wd_clr) begin
			r_nxt.wd[WD_STOP_OFF_BIT] = 1'b0;
			r_nxt.wake_a[WAKE_STOP_WD_BIT] = 1'b0;
		end
		// set wins over clear
		if (i_spi_fail_clr && !wd_par_err) begin
			r_nxt.spi_fail = 1'b0;
		end
		if (restart_entry) begin
			r_nxt.wd = (r.wd & RSTRT_KEEP_WD) | RSTRT_SET_WD;
			r_nxt.bus_b = r.bus_b & RSTRT_KEEP_BUS_B;
			r_nxt.wake_a = r.wake_a & RSTRT_KEEP_WAKE_A;
			r_nxt.wake_b = r.wake_b & RSTRT_KEEP_WAKE_B;
		end
		if (i_soft_rst) begin
			r_nxt.wd = RST_WATCHDOG_CONTROL_REG;
			r_nxt.bus_a = RST_BUS_A;
			r_nxt.bus_b = RST_BUS_B;
			r_nxt.wake_a = RST_WAKE_A;
			r_nxt.wake_b = RST_WAKE_B;
		end
		// reset limiting counts consecutive watchdog resets
		if (i_wd_trigger_ok) begin
			r_nxt.wd_rst_cnt = 2'd0;
		end else if (i_wd_fail) begin
			if (!r.wd[WD_LIMIT_BIT] || r.wd_rst_cnt != WD_MAX_RESETS) begin
				r_nxt.wd_reset = 1'b1;
			end
			if (r.wd_rst_cnt != WD_MAX_RESETS) begin
				r_nxt.wd_rst_cnt = r.wd_rst_cnt + 2'd1;
			end
		end
		case (r.wd[WD_PER_MSB:0])
			3'b000: r_nxt.period_ms = WD_MS_0;
			3'b001: r_nxt.period_ms = WD_MS_1;
			3'b010: r_nxt.period_ms = WD_MS_2;
			3'b011: r_nxt.period_ms = WD_MS_3;
			3'b100: r_nxt.period_ms = WD_MS_4;
			3'b101: r_nxt.period_ms = WD_MS_5;
			default: r_nxt.period_ms = 9'd0;
		endcase
		r_nxt.trx.can = eff_mode(r.bus_a[LIN_LO_LSB +: 2], i_sys_mode);
		r_nxt.trx.first_lin_mode = eff_mode(r.bus_a[LIN_HI_LSB +: 2], i_sys_mode);
		r_nxt.trx.second_lin_mode = eff_mode(r.bus_b[LIN_LO_LSB +: 2], i_sys_mode);
		r_nxt.trx.third_lin_mode = eff_mode(r.bus_b[LIN_HI_LSB +: 2], i_sys_mode);
		r_nxt.stop_wd_off = r.wd[WD_STOP_OFF_BIT] | r.wake_a[WAKE_STOP_WD_BIT];
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			r <= '0;
			r.wd <= RST_WATCHDOG_CONTROL_REG;
			r.bus_a <= RST_BUS_A;
			r.bus_b <= RST_BUS_B;
			r.wake_a <= RST_WAKE_A;
			r.wake_b <= RST_WAKE_B;
			r.csn_prev <= 1'b1;
			r.period_ms <= WD_MS_4;
		end else if (i_clk_en) begin
			r <= r_nxt;
		end
	end

	assign o_spi_sdo = r.sdo;
	assign o_spi_fail = r.spi_fail;
	assign o_trx_mode = r.trx;
	assign o_lin_slope_off = r.bus_a[BUS_FLASH_BIT];
	assign o_lin_low_slope_sel = r.bus_a[BUS_LSM_BIT];
	assign o_lin_tx_dominant_timeout_en = r.bus_a[BUS_TXDTO_BIT];
	assign o_periodic_timer_wake_en = r.wake_a[WAKE_TIMER_BIT];
	assign o_wake_pin_source_en = r.wake_b[WAKE_PIN_BIT];
	assign o_stop_watchdog_off = r.stop_wd_off;
	assign o_watchdog_window_sel = r.wd[WATCHDOG_WINDOW_SEL_BIT];
	assign o_watchdog_period_ms = r.period_ms;
	assign o_wd_reset = r.wd_reset;

	// checks
	logic wd_bad_write;
	assign wd_bad_write = frame_end && r.bit_cnt == 5'(SPI_FRAME_BITS) && rx_wr
		&& rx_addr == ADDR_WATCHDOG_CONTROL_REG && (^rx_data) && !i_soft_rst && !restart_entry
		&& !i_hw_stop_wd_set && !i_hw_stop_wd_clr;

	sequence s_fail_taken;
		i_clk_en && i_wd_fail && !i_wd_trigger_ok;
	endsequence

	sequence s_low_power_normal_can;
		i_clk_en && (i_sys_mode == SYS_STOP || i_sys_mode == SYS_SLEEP)
			&& r.bus_a[1:0] == 2'b11
			&& !i_soft_rst && !(frame_end && rx_wr && rx_addr == ADDR_BUS_A);
	endsequence

	property p_limit_blocks;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_fail_taken and (r.wd[WD_LIMIT_BIT] && r.wd_rst_cnt == WD_MAX_RESETS) |=> !o_wd_reset;
	endproperty
	a_limit_blocks: assert property (p_limit_blocks) else $error("reset issued past limit");

	property p_no_limit_resets;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_fail_taken and !r.wd[WD_LIMIT_BIT] |=> o_wd_reset ##1 (!o_wd_reset || $past(i_wd_fail));
	endproperty
	a_no_limit_resets: assert property (p_no_limit_resets) else $error("missing wd reset");

	property p_period_500;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && r.wd[2:0] == 3'b101 |=> o_watchdog_period_ms == 9'd500;
	endproperty
	a_period_500: assert property (p_period_500) else $error("period decode wrong");

	property p_can_override;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_low_power_normal_can |=> o_trx_mode.can == TRX_WAKE && r.bus_a[1:0] == 2'b11;
	endproperty
	a_can_override: assert property (p_can_override) else $error("can not wake capable");

	property p_lin_restore;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_sys_mode == SYS_NORMAL && r.bus_b[4:3] == 2'b11
			|=> o_trx_mode.third_lin_mode == TRX_NORMAL;
	endproperty
	a_lin_restore: assert property (p_lin_restore) else $error("lin normal not restored");

	property p_reserved_zero;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(r.bus_a[2] == 1'b0) && (r.bus_b[7:5] == 3'b000) && (r.wake_b[7:1] == 7'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_parity_reject;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && wd_bad_write |=> o_spi_fail && $stable(r.wd);
	endproperty
	a_parity_reject: assert property (p_parity_reject) else $error("bad parity accepted");

	property p_restart_bus_b;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && restart_entry && !i_soft_rst
			|=> r.bus_b == ($past(r.bus_b) & 8'h1B) && r.wake_b == ($past(r.wake_b) & 8'h01);
	endproperty
	a_restart_bus_b: assert property (p_restart_bus_b) else $error("restart value wrong");

	property p_hw_stop_wd;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_hw_stop_wd_set && !i_soft_rst && !restart_entry
			|=> r.wake_a[2] ##1 (o_stop_watchdog_off || !$past(i_clk_en));
	endproperty
	a_hw_stop_wd: assert property (p_hw_stop_wd) else $error("hw stop wd not taken");

	property p_fail_set_wins;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && wd_par_err |=> o_spi_fail;
	endproperty
	a_fail_set_wins: assert property (p_fail_set_wins) else $error("fail flag lost");

	property p_freeze;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_clk_en |=> $stable(o_trx_mode) && $stable(o_spi_fail) && $stable(o_wd_reset);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_soft_defaults;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_soft_rst
			|=> r.bus_a == RST_BUS_A && r.bus_b == RST_BUS_B && r.wake_b == RST_WAKE_B;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset value wrong");

	property p_restart_wake;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && restart_entry && !i_soft_rst
			|=> o_wake_pin_source_en == $past(r.wake_b[WAKE_PIN_BIT]) && r.wake_b[7:1] == 7'h00;
	endproperty
	a_restart_wake: assert property (p_restart_wake) else $error("wake pin not kept");

	property p_third_lin_mode_override;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && (i_sys_mode == SYS_STOP || i_sys_mode == SYS_SLEEP) && r.bus_b[4:3] == 2'b11
			|=> o_trx_mode.third_lin_mode == TRX_WAKE;
	endproperty
	a_third_lin_mode_override: assert property (p_third_lin_mode_override) else $error("lin not wake capable");

	property p_second_lin_mode_rx_kept;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_sys_mode != SYS_NORMAL && r.bus_b[1:0] == 2'b10
			|=> o_trx_mode.second_lin_mode == TRX_RX_ONLY;
	endproperty
	a_second_lin_mode_rx_kept: assert property (p_second_lin_mode_rx_kept) else $error("receive-only lost");
endmodule : bwwc_ctrl_regs

// >>> testbench/bwwc_host_model.sv
// host serial master model driving the control register bank
`timescale 1ns/10ps
module bwwc_host_model
	import bwwc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_spi_sdo,
	output bwwc_spi_in_t o_spi,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data
);
	initial begin
		o_spi = '{csn_n: 1'b1, sck: 1'b0, sdi: 1'b0};
		o_rd_valid = 1'b0;
		o_rd_data = 8'h00;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk_sys);
		#10;
	endtask : wt
	// lsb first: address, write flag, data; sdo taken just before each data rise
	task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d);
		logic [15:0] f;
		f = {d, w, a};
		o_spi.csn_n = 1'b0;
		o_spi.sdi = f[0];
		wt(2);
		for (int b = 0; b < 16; b++) begin
			if (b > 7) o_rd_data[b-8] = i_spi_sdo;
			o_spi.sck = 1'b1;
			wt(2);
			o_spi.sck = 1'b0;
			// released data line shows the inverse, not a stale bit
			o_spi.sdi = (b == 15) ? ~f[15] : f[b+1];
			wt(2);
		end
		o_spi.csn_n = 1'b1;
		wt(2);
		o_rd_valid = ~w;
		wt(1);
		o_rd_valid = 1'b0;
	endtask : xfer
endmodule : bwwc_host_model

// >>> testbench/bus_wake_watchdog_ctrl_regs_test.sv
// self-checking bench for the control register bank
`timescale 1ns/10ps
module bus_wake_watchdog_ctrl_regs_test;
	import bwwc_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic i_soft_rst = 1'b0, i_wd_fail = 1'b0, i_wd_trigger_ok = 1'b0;
	logic i_hw_stop_wd_set = 1'b0, i_hw_stop_wd_clr = 1'b0, i_spi_fail_clr = 1'b0;
	bwwc_sys_t i_sys_mode = SYS_NORMAL;
	bwwc_spi_in_t spi;
	bwwc_trx_set_t trx;
	logic sdo, fail, slo, lsm, txto, tmr, pin, swd, win, wdr, rd_v, look_v = 1'b0;
	logic [8:0] per;
	logic [7:0] rd_d, w;
	logic [15:0] vec, obs, got, wd_cnt = 16'h0000;
	logic [1:0] look_sel = 2'd0;
	logic [15:0] exp_q[$];
	int fail_count = 0;
	int comparisons = 0;
	logic [7:0] d [4];
	logic [7:0] msk [4] = '{WMASK_BUS_A, WMASK_BUS_B, WMASK_WAKE_A, WMASK_WAKE_B};
	logic [8:0] ms [8] = '{9'h00A, 9'h014, 9'h032, 9'h064, 9'h0C8, 9'h1F4, 9'h000, 9'h000};
	bwwc_ctrl_regs i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
		.i_spi(spi), .i_sys_mode(i_sys_mode), .i_soft_rst(i_soft_rst), .i_wd_fail(i_wd_fail),
		.i_wd_trigger_ok(i_wd_trigger_ok), .i_hw_stop_wd_set(i_hw_stop_wd_set),
		.i_hw_stop_wd_clr(i_hw_stop_wd_clr), .i_spi_fail_clr(i_spi_fail_clr), .o_spi_sdo(sdo),
		.o_spi_fail(fail), .o_trx_mode(trx), .o_lin_slope_off(slo), .o_lin_low_slope_sel(lsm),
		.o_lin_tx_dominant_timeout_en(txto), .o_periodic_timer_wake_en(tmr),
		.o_wake_pin_source_en(pin), .o_stop_watchdog_off(swd), .o_watchdog_window_sel(win),
		.o_watchdog_period_ms(per), .o_wd_reset(wdr));
	bwwc_host_model i_host (.i_clk_sys(i_clk_sys), .i_spi_sdo(sdo), .o_spi(spi),
		.o_rd_valid(rd_v), .o_rd_data(rd_d));
	assign vec = {trx, slo, lsm, txto, tmr, pin, swd, win, fail};
	assign obs = (look_sel == 2'd0) ? vec : (look_sel == 2'd1) ? {win, fail, 5'h00, per} :
		(look_sel == 2'd2) ? wd_cnt : {8'h00, trx};
	initial begin
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		if (wdr === 1'b1) wd_cnt <= wd_cnt + 16'h0001;
		if (rd_v === 1'b1 || look_v === 1'b1) begin
			got = (look_v === 1'b1) ? obs : {8'h00, rd_d};
			comparisons++;
			if (exp_q.size() == 0 || got !== exp_q[0]) begin
				fail_count++;
				$display("CHECK FAILED t=%0t got %h", $time, got);
			end
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#10;
	endtask : step
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		i_host.xfer(a, 1'b1, v);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		i_host.xfer(a, 1'b0, 8'h00);
		step(1);
	endtask : rd
	task automatic peek(input logic [1:0] s, input logic [15:0] e);
		exp_q.push_back(e);
		look_sel = s;
		look_v = 1'b1;
		step(1);
		look_v = 1'b0;
		step(1);
	endtask : peek
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask : pulse
	function automatic logic [15:0] vexp(logic [7:0] a, b, c, e);
		return {a[1:0], a[4:3], b[1:0], b[4:3], a[7], a[6], a[5], c[6], e[0], c[2], 2'b00};
	endfunction : vexp
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (40000) @(posedge i_clk_sys);
		fail_count++;
		complete_run;
	end
	initial begin
		void'($urandom(97975));
		step(10);
		i_rst_n = 1'b1;
		step(1);
		rd(ADDR_WATCHDOG_CONTROL_REG, RST_WATCHDOG_CONTROL_REG);
		rd(ADDR_BUS_A, RST_BUS_A);
		rd(ADDR_BUS_B, RST_BUS_B);
		rd(ADDR_WAKE_A, RST_WAKE_A);
		rd(ADDR_WAKE_B, RST_WAKE_B);
		rd(7'h10, 8'h00);
		$display("test reset values done");
		for (int n = 0; n < 4; n++) begin
			for (int r = 0; r < 4; r++) begin
				d[r] = (n == 0) ? 8'hFF : 8'($urandom);
				wr(7'(4 + r), d[r]);
			end
			for (int r = 0; r < 4; r++) rd(7'(4 + r), d[r] & msk[r]);
			peek(2'd0, vexp(d[0], d[1], d[2], d[3]));
		end
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_BUS_A, {3'b000, 2'(c), 1'b0, 2'(c)});
			wr(ADDR_BUS_B, {3'b000, 2'(c), 1'b0, 2'(c)});
			peek(2'd3, {8'h00, {4{2'(c)}}});
		end
		$display("test field access done");
		wr(ADDR_BUS_B, 8'h1A);
		i_sys_mode = SYS_STOP;
		step(1);
		peek(2'd3, 16'h0059);
		rd(ADDR_BUS_A, 8'h1B);
		rd(ADDR_BUS_B, 8'h1A);
		i_sys_mode = SYS_NORMAL;
		step(1);
		peek(2'd3, 16'h00FB);
		wr(ADDR_BUS_A, 8'h19);
		clk_en = 1'b0;
		i_sys_mode = SYS_SLEEP;
		step(2);
		peek(2'd3, 16'h007B); // frozen while the enable is low
		clk_en = 1'b1;
		step(1);
		peek(2'd3, 16'h0059);
		i_sys_mode = SYS_NORMAL;
		$display("test mode override done");
		for (int c = 0; c < 8; c++) begin
			w = {2'b00, 1'(c), 2'b00, 3'(c)};
			w[7] = ^w[6:0];
			wr(ADDR_WATCHDOG_CONTROL_REG, w);
			peek(2'd1, {1'(c), 6'h00, ms[c]});
		end
		wr(ADDR_WATCHDOG_CONTROL_REG, 8'h02);
		peek(2'd1, 16'h8000 | 16'h4000);
		pulse(i_spi_fail_clr);
		peek(2'd1, 16'h8000);
		$display("test watchdog setup done");
		repeat (4) pulse(i_wd_fail);
		peek(2'd2, 16'h0004);
		pulse(i_wd_trigger_ok);
		wr(ADDR_WATCHDOG_CONTROL_REG, 8'h0C);
		wd_cnt = 16'h0000;
		repeat (4) pulse(i_wd_fail);
		peek(2'd2, 16'h0003);
		$display("test reset limit done");
		for (int r = 0; r < 4; r++) wr(7'(4 + r), 8'hFF);
		i_sys_mode = SYS_RESTART;
		step(2);
		rd(ADDR_BUS_B, 8'h1B);
		rd(ADDR_WAKE_A, 8'h40);
		rd(ADDR_WAKE_B, 8'h01);
		rd(ADDR_BUS_A, 8'hFB);
		i_sys_mode = SYS_NORMAL;
		wr(ADDR_WAKE_B, 8'h00);
		pulse(i_soft_rst);
		rd(ADDR_BUS_B, RST_BUS_B);
		rd(ADDR_WAKE_B, RST_WAKE_B);
		pulse(i_hw_stop_wd_set);
		rd(ADDR_WAKE_A, 8'h04);
		peek(2'd0, 16'h002C);
		pulse(i_hw_stop_wd_clr);
		rd(ADDR_WAKE_A, 8'h00);
		$display("test restart and hardware update done");
		complete_run;
	end
endmodule : bus_wake_watchdog_ctrl_regs_test
